// >>> src/sfp_front_end.sv
// pin front end of a serial flash spi port, sampled on clk_sys
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "sfp_cfg.svh"

module sfp_front_end (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] lane_in,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe,
  input wire logic reinit_n_pin,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_is_cmd,
  input wire logic tx_en,
  input wire logic [7:0] tx_byte,
  output logic tx_req,
  output logic core_reset,
  output logic status_write_block
);
  import sfp_pkg::*;

  localparam logic [11:0] SRST_CYC = 12'(`SFP_SRST_CYC);
  localparam logic [7:0] HW_CYC = 8'(`SFP_HW_CYC);

  sfp_state_t q;
  sfp_state_t n;

  logic cs_low;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic shared_pause;
  logic shared_rst;
  logic hw_low;
  logic blocked;
  logic [7:0] sh_in;
  logic [3:0] cnt_in;
  logic [7:0] tb;
  logic [3:0] tcnt;

  assign cs_low = ~q.cs_s;
  // previous level resets low, so a select held low from reset is no edge
  assign cs_fall = q.cs_p & ~q.cs_s;
  assign sclk_rise = ~q.sclk_p & q.sclk_s;
  assign sclk_fall = q.sclk_p & ~q.sclk_s;
  assign shared_pause = ~q.cfg_qe & ~q.cfg_sel;
  assign shared_rst = ~q.cfg_qe & q.cfg_sel;
  assign hw_low = ~q.rpin_s | (shared_rst & ~q.lane_s[3]);
  assign blocked = hw_low | (q.srst_cnt != 12'h000);

  always_comb begin
    n = q;
    sh_in = q.rx_sh;
    cnt_in = q.rx_cnt;
    tb = q.tx_sh;
    tcnt = q.tx_cnt;
    n.rx_valid = 1'b0;
    n.tx_req = 1'b0;
    n.core_reset = 1'b0;
    n.cs_m = cs_n_pin;
    n.cs_s = q.cs_m;
    n.cs_p = q.cs_s;
    n.sclk_m = sclk_pin;
    n.sclk_s = q.sclk_m;
    n.sclk_p = q.sclk_s;
    n.lane_m = lane_in;
    n.lane_s = q.lane_m;
    n.rpin_m = reinit_n_pin;
    n.rpin_s = q.rpin_m;

    // pause only follows its pin while the clock is low
    if (!cs_low || !shared_pause) begin
      n.pause = 1'b0;
    end else if (!q.sclk_s) begin
      n.pause = ~q.lane_s[3];
    end

    if (hw_low) begin
      if (q.hw_cnt != HW_CYC) begin
        n.hw_cnt = q.hw_cnt + 8'h01;
      end
      if (q.hw_cnt == HW_CYC - 8'h01) begin
        n.hw_done = 1'b1;
        n.core_reset = 1'b1;
      end
    end else begin
      n.hw_cnt = 8'h00;
      n.hw_done = 1'b0;
    end

    if (q.srst_cnt != 12'h000) begin
      n.srst_cnt = q.srst_cnt - 12'h001;
    end

    if (blocked) begin
      n.ph = SFP_PH_OFF;
      n.rx_cnt = 4'h0;
      n.tx_cnt = 4'h0;
      n.txon = 1'b0;
      n.cand66 = 1'b0;
      if (hw_low) begin
        n.prev66 = 1'b0;
        n.srst_cnt = 12'h000;
      end
    end else if (!cs_low) begin
      if (q.ph != SFP_PH_OFF) begin
        n.prev66 = q.cand66;
      end
      n.ph = SFP_PH_OFF;
      n.rx_cnt = 4'h0;
      n.tx_cnt = 4'h0;
      n.txon = 1'b0;
      n.cand66 = 1'b0;
    end else if (cs_fall) begin
      n.ph = SFP_PH_CMD;
      n.rx_cnt = 4'h0;
      n.tx_cnt = 4'h0;
      n.txon = 1'b0;
      n.win = 3'h1;
      n.wout = 3'h1;
      n.cand66 = 1'b0;
    end else if (q.ph != SFP_PH_OFF && q.ph != SFP_PH_IGN && !q.pause) begin
      if (sclk_rise) begin
        case (q.win)
          3'h2: sh_in = {q.rx_sh[5:0], q.lane_s[1], q.lane_s[0]};
          3'h4: sh_in = {q.rx_sh[3:0], q.lane_s[3:0]};
          default: sh_in = {q.rx_sh[6:0], q.lane_s[0]};
        endcase
        cnt_in = q.rx_cnt + {1'b0, q.win};
        n.rx_sh = sh_in;
        n.rx_cnt = cnt_in;
        if (cnt_in == 4'h8) begin
          n.rx_cnt = 4'h0;
          n.rx_byte = sh_in;
          n.rx_valid = 1'b1;
          n.rx_is_cmd = (q.ph == SFP_PH_CMD);
          if (q.ph == SFP_PH_CMD) begin
            n.ph = SFP_PH_BODY;
            n.prev66 = 1'b0;
            case (sh_in)
              `SFP_OP_DUAL_OUT: begin
                n.wout = 3'h2;
              end
              `SFP_OP_DUAL_IO: begin
                n.win = 3'h2;
                n.wout = 3'h2;
              end
              `SFP_OP_QUAD_OUT: begin
                if (q.cfg_qe) begin
                  n.wout = 3'h4;
                end else begin
                  n.ph = SFP_PH_IGN;
                  n.rx_valid = 1'b0;
                end
              end
              `SFP_OP_QUAD_IO: begin
                if (q.cfg_qe) begin
                  n.win = 3'h4;
                  n.wout = 3'h4;
                end else begin
                  n.ph = SFP_PH_IGN;
                  n.rx_valid = 1'b0;
                end
              end
              `SFP_OP_RST_EN: begin
                n.cand66 = 1'b1;
              end
              `SFP_OP_RST: begin
                if (q.prev66) begin
                  n.srst_cnt = SRST_CYC;
                  n.core_reset = 1'b1;
                  n.ph = SFP_PH_IGN;
                end
              end
              default: begin
              end
            endcase
          end else begin
            // enable-reset only counts when it was the whole instruction
            n.cand66 = 1'b0;
          end
        end
      end
      if (sclk_fall && q.ph == SFP_PH_BODY && tx_en) begin
        if (q.tx_cnt == 4'h0) begin
          tb = tx_byte;
          tcnt = 4'h8;
          n.tx_req = 1'b1;
        end
        case (q.wout)
          3'h2: n.lane_out = {2'b00, tb[7], tb[6]};
          3'h4: n.lane_out = tb[7:4];
          default: n.lane_out = {2'b00, tb[7], 1'b0};
        endcase
        n.tx_sh = 8'(tb << q.wout);
        n.tx_cnt = tcnt - {1'b0, q.wout};
        n.txon = 1'b1;
      end
    end

    // drive only lanes that belong to the current width
    if (n.txon && !n.pause && n.ph == SFP_PH_BODY) begin
      case (n.wout)
        3'h2: n.lane_oe = 4'h3;
        3'h4: n.lane_oe = 4'hf;
        default: n.lane_oe = 4'h2;
      endcase
    end else begin
      n.lane_oe = 4'h0;
    end

    n.wblock = q.cfg_srp & ~q.lane_s[2] & ~q.cfg_qe;

    if (reg_wr) begin
      if (reg_addr == `SFP_CFG_OFS) begin
        n.cfg_qe = reg_wdata[`SFP_CFG_QE_BIT];
        n.cfg_sel = reg_wdata[`SFP_CFG_SEL_BIT];
        n.cfg_srp = reg_wdata[`SFP_CFG_SRP_BIT];
      end
    end
    if (reg_rd) begin
      if (reg_addr == `SFP_CFG_OFS) begin
        n.rd_data = {5'h00, q.cfg_srp, q.cfg_sel, q.cfg_qe};
      end else if (reg_addr == `SFP_STAT_OFS) begin
        n.rd_data = {3'h0, q.wblock, hw_low, q.srst_cnt != 12'h000,
                     q.pause, q.ph != SFP_PH_OFF};
      end else begin
        n.rd_data = 8'h00;
      end
    end else begin
      n.rd_data = 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
      {q.cfg_srp, q.cfg_sel, q.cfg_qe} <= `SFP_CFG_RST;
      // reset pin and lane chains start at their pulled-up idle level,
      // so no false pause or reset-pin low shows up right after reset;
      // select keeps its low start so a held-low select is no edge
      q.rpin_m <= 1'b1;
      q.rpin_s <= 1'b1;
      q.lane_m <= 4'hf;
      q.lane_s <= 4'hf;
    end else begin
      q <= n;
    end
  end

  assign lane_out = q.lane_out;
  assign lane_oe = q.lane_oe;
  assign reg_rdata = q.rd_data;
  assign rx_byte = q.rx_byte;
  assign rx_valid = q.rx_valid;
  assign rx_is_cmd = q.rx_is_cmd;
  assign tx_req = q.tx_req;
  assign core_reset = q.core_reset;
  assign status_write_block = q.wblock;

  chk_deselect_float: assert property (
    @(posedge clk_sys) disable iff (rst)
    q.cs_s |=> q.lane_oe == 4'h0)
    else $error("lanes driven while deselected");

  chk_reset_no_cmd: assert property (
    @(posedge clk_sys) disable iff (rst)
    hw_low ##1 hw_low |=> !q.rx_valid)
    else $error("byte taken during hardware reset");

  chk_reset_pulse_len: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(q.hw_done) |-> q.core_reset && q.hw_cnt == HW_CYC)
    else $error("hardware reset fired at wrong count");

  chk_quad_gate: assert property (
    @(posedge clk_sys) disable iff (rst)
    q.lane_oe == 4'hf |-> q.cfg_qe && q.wout == 3'h4)
    else $error("quad lanes driven without quad enable");

  chk_dual_lanes: assert property (
    @(posedge clk_sys) disable iff (rst)
    q.lane_oe == 4'h3 |-> q.wout == 3'h2)
    else $error("dual lanes driven outside dual read");

  chk_pause_float: assert property (
    @(posedge clk_sys) disable iff (rst)
    q.pause |-> q.lane_oe == 4'h0)
    else $error("output driven during pause");

  chk_pause_keeps: assert property (
    @(posedge clk_sys) disable iff (rst)
    q.pause && !blocked && cs_low |=> $stable(q.rx_sh) && $stable(q.rx_cnt))
    else $error("receive state changed during pause");

  chk_qe_no_pause: assert property (
    @(posedge clk_sys) disable iff (rst)
    q.cfg_qe |=> !q.pause)
    else $error("pause active with quad enable");

  chk_soft_busy: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(q.srst_cnt != 12'h000) |-> q.srst_cnt == SRST_CYC
      ##1 (!q.rx_valid && q.ph == SFP_PH_OFF)[*8])
    else $error("soft reset busy period broken");

  chk_wp_quad: assert property (
    @(posedge clk_sys) disable iff (rst)
    q.cfg_qe ##1 q.cfg_qe |=> !q.wblock)
    else $error("write block asserted in quad mode");

  chk_rise_sample: assert property (
    @(posedge clk_sys) disable iff (rst)
    q.rx_cnt != $past(q.rx_cnt) && q.rx_cnt != 4'h0 |-> $past(sclk_rise))
    else $error("bit taken without rising clock");

  chk_blocked_idle: assert property (
    @(posedge clk_sys) disable iff (rst)
    blocked |=> q.ph == SFP_PH_OFF && !q.rx_valid)
    else $error("frame active while a reset holds the port");

  chk_frame_first: assert property (
    @(posedge clk_sys) disable iff (rst)
    q.rx_valid |-> $past(q.ph) != SFP_PH_OFF)
    else $error("byte taken outside a selected frame");

  chk_pause_select: assert property (
    @(posedge clk_sys) disable iff (rst)
    !shared_pause |=> !q.pause)
    else $error("pause active while pin serves another function");

  chk_pause_start: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(q.pause) |-> !$past(q.sclk_s))
    else $error("pause began while clock high");

  chk_pause_end: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(q.pause) |-> !$past(q.sclk_s) || !$past(cs_low) ||
      !$past(shared_pause))
    else $error("pause ended while clock high");

  chk_tx_on_fall: assert property (
    @(posedge clk_sys) disable iff (rst)
    q.tx_req |-> $past(sclk_fall))
    else $error("transmit byte taken without falling clock");

  chk_soft_cause: assert property (
    @(posedge clk_sys) disable iff (rst)
    q.core_reset |-> $past(hw_low) || $past(q.prev66))
    else $error("core reset without a reset cause");

endmodule : sfp_front_end

// >>> src/sfp_cfg.svh
// constants of the serial flash pin front end
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

`define SFP_CFG_OFS 4'h0
`define SFP_STAT_OFS 4'h4

`define SFP_CFG_QE_BIT 0
`define SFP_CFG_SEL_BIT 1
`define SFP_CFG_SRP_BIT 2
`define SFP_CFG_RST 3'h0

`define SFP_OP_DUAL_OUT 8'h3b
`define SFP_OP_DUAL_IO 8'hbb
`define SFP_OP_QUAD_OUT 8'h6b
`define SFP_OP_QUAD_IO 8'heb
`define SFP_OP_RST_EN 8'h66
`define SFP_OP_RST 8'h99

`define SFP_CLK_PERIOD_NS 10
`define SFP_SOFT_RESET_NS 30000
`define SFP_RESET_PULSE_NS 1000
`define SFP_SRST_CYC \
  ((`SFP_SOFT_RESET_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)
`define SFP_HW_CYC \
  ((`SFP_RESET_PULSE_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)

`endif

// >>> src/sfp_pkg.sv
// types of the serial flash pin front end
package sfp_pkg;

  typedef enum logic [1:0] {
    SFP_PH_OFF  = 2'b00,
    SFP_PH_CMD  = 2'b01,
    SFP_PH_BODY = 2'b10,
    SFP_PH_IGN  = 2'b11
  } sfp_phase_t;

  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_p;
    logic sclk_m;
    logic sclk_s;
    logic sclk_p;
    logic [3:0] lane_m;
    logic [3:0] lane_s;
    logic rpin_m;
    logic rpin_s;
    sfp_phase_t ph;
    logic [2:0] win;
    logic [2:0] wout;
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic txon;
    logic pause;
    logic cand66;
    logic prev66;
    logic [11:0] srst_cnt;
    logic [7:0] hw_cnt;
    logic hw_done;
    logic cfg_qe;
    logic cfg_sel;
    logic cfg_srp;
    logic [7:0] rd_data;
    logic [3:0] lane_out;
    logic [3:0] lane_oe;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic rx_is_cmd;
    logic tx_req;
    logic core_reset;
    logic wblock;
  } sfp_state_t;

endpackage : sfp_pkg

// >>> sim/sfp_spi_master.sv
// spi bus master model: select, serial clock and data lanes
`timescale 1ns/1ps
module sfp_spi_master (
  input wire logic clk_sys,
  input wire logic [3:0] lane_pin,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] m_out,
  output logic [3:0] m_oe
);
  logic mode3 = 1'b0;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    m_out = 4'h0;
    m_oe = 4'h0;
  end
  // clock parked at the idle level of the mode before select falls
  task start(input logic m3);
    mode3 = m3;
    sclk <= m3;
    repeat (4) @(posedge clk_sys);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : start
  // lanes change on the fall, read late in the high phase
  task sh(input int w, input logic rd, input logic [7:0] d,
          output logic [7:0] q);
    int i;
    q = 8'h00;
    for (i = 0; i < 8 / w; i++) begin
      sclk <= 1'b0;
      m_oe <= rd ? 4'h0 : 4'((1 << w) - 1);
      m_out <= 4'(d >> (8 - w * (i + 1)));
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      q = 8'(q << w) | ((w == 1) ? {7'h0, lane_pin[1]} :
          8'(lane_pin & 4'((1 << w) - 1)));
    end
  endtask : sh
  task fall();
    sclk <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask : fall
  // select stays low until here, also across a pause
  task stop();
    sclk <= mode3;
    m_oe <= 4'h0;
    repeat (4) @(posedge clk_sys);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask : stop
endmodule : sfp_spi_master

// >>> sim/serial_flash_spi_pin_front_end_tb.sv
// self-checking bench of the serial flash pin front end
`timescale 1ns/1ps
module serial_flash_spi_pin_front_end_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sclk, reinit_n_pin = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] lane_in, lane_out, lane_oe, m_out, m_oe, lvl = 4'hf;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rx_byte, tx_byte = 8'h00, q;
  logic rx_valid, rx_is_cmd, tx_en = 1'b0, tx_req, core_reset, wblk;
  logic [8:0] rxq[$];
  int num_errors = 0, checks = 0, nrst = 0, cyc = 0, ntx = 0;
  // undriven lanes sit at their pull level, held in lvl
  assign lane_in = (lane_oe & lane_out) | (~lane_oe & m_oe & m_out) |
                   (~lane_oe & ~m_oe & lvl);
  sfp_front_end DUT (
    .clk_sys(clk_sys),
    .rst(rst),
    .cs_n_pin(cs_n),
    .sclk_pin(sclk),
    .lane_in(lane_in),
    .lane_out(lane_out),
    .lane_oe(lane_oe),
    .reinit_n_pin(reinit_n_pin),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid),
    .rx_is_cmd(rx_is_cmd),
    .tx_en(tx_en),
    .tx_byte(tx_byte),
    .tx_req(tx_req),
    .core_reset(core_reset),
    .status_write_block(wblk)
  );
  sfp_spi_master m (
    .clk_sys(clk_sys),
    .lane_pin(lane_in),
    .cs_n(cs_n),
    .sclk(sclk),
    .m_out(m_out),
    .m_oe(m_oe)
  );
  always #5 clk_sys = ~clk_sys;
  // monitors sample on the falling edge, clear of register updates
  always @(negedge clk_sys) begin
    if (rx_valid === 1'b1) rxq.push_back({rx_is_cmd, rx_byte});
    if (core_reset === 1'b1) nrst++;
    if (tx_req === 1'b1) ntx++;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task test_done();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task chk(input logic [8:0] g, input logic [8:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task rxe(input logic [8:0] e);
    chk(rxq.size() > 0 ? rxq.pop_front() : 9'h1ff, e);
  endtask : rxe
  task wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk({1'b0, reg_rdata}, {1'b0, e});
    @(posedge clk_sys);
  endtask : rd
  // instruction, optional input byte, then read byte with tx_en raised
  task rdf(input logic m3, input logic [7:0] op, input int w,
           input logic [7:0] tb, input logic [3:0] oe);
    int wi;
    // output-only reads send their address byte on one lane
    wi = (op == 8'h3b || op == 8'h6b) ? 1 : w;
    ntx = 0;
    tx_byte <= tb;
    m.start(m3);
    m.sh(1, 1'b0, op, q);
    if (op != 8'h0b) m.sh(wi, 1'b0, 8'h96, q);
    tx_en <= 1'b1;
    m.sh(w, 1'b1, 8'h00, q);
    chk({1'b0, q}, {1'b0, tb});
    chk({5'h0, lane_oe}, {5'h0, oe});
    chk(9'(ntx), 9'h1);
    tx_en <= 1'b0;
    m.stop();
    chk({5'h0, lane_oe}, 9'h0);
    rxe({1'b1, op});
    if (op != 8'h0b) rxe(9'h096);
    // lanes are still taken in during the read; an output-only read
    // leaves only a partial byte, dropped when select rises
    if (wi == w) rxe({1'b0, ((w == 1) ? 8'hff : tb)});
  endtask : rdf
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h00);
    wr(4'h0, 8'h07);
    rd(4'h0, 8'h07);
    $display("registers done");
    rdf(1'b1, 8'h0b, 1, 8'h5a, 4'h2);
    rdf(1'b0, 8'hbb, 2, 8'hc3, 4'h3);
    rdf(1'b1, 8'h3b, 2, 8'h69, 4'h3);
    wr(4'h0, 8'h00);
    m.start(1'b0);
    m.sh(1, 1'b0, 8'h6b, q);
    m.sh(1, 1'b0, 8'h11, q);
    m.stop();
    chk(9'(rxq.size()), 9'h0);
    wr(4'h0, 8'h01);
    rdf(1'b0, 8'heb, 4, 8'he7, 4'hf);
    rdf(1'b1, 8'h6b, 4, 8'h1e, 4'hf);
    $display("lanes done");
    wr(4'h0, 8'h00);
    m.start(1'b0);
    m.sh(1, 1'b0, 8'h05, q);
    lvl[3] <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(4'h4, 8'h01);
    m.fall();
    rd(4'h4, 8'h03);
    m.sh(1, 1'b0, 8'hff, q);
    chk({5'h0, lane_oe}, 9'h0);
    lvl[3] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(4'h4, 8'h03);
    m.fall();
    rd(4'h4, 8'h01);
    m.sh(1, 1'b0, 8'ha5, q);
    m.stop();
    rxe(9'h105);
    rxe(9'h0a5);
    $display("pause done");
    m.start(1'b0);
    m.sh(1, 1'b0, 8'h66, q);
    m.stop();
    m.start(1'b0);
    m.sh(1, 1'b0, 8'h99, q);
    m.stop();
    rxe(9'h166);
    rxe(9'h199);
    chk(9'(nrst), 9'h1);
    rd(4'h4, 8'h04);
    m.start(1'b0);
    m.sh(1, 1'b0, 8'h03, q);
    m.stop();
    chk(9'(rxq.size()), 9'h0);
    repeat (3000) @(posedge clk_sys);
    rd(4'h4, 8'h00);
    $display("soft reset done");
    wr(4'h0, 8'h02);
    lvl[3] <= 1'b0;
    repeat (120) @(posedge clk_sys);
    rd(4'h4, 8'h08);
    chk(9'(nrst), 9'h2);
    wr(4'h0, 8'h03);
    repeat (120) @(posedge clk_sys);
    rd(4'h4, 8'h00);
    reinit_n_pin <= 1'b0;
    repeat (120) @(posedge clk_sys);
    rd(4'h4, 8'h08);
    chk(9'(nrst), 9'h3);
    reinit_n_pin <= 1'b1;
    lvl[3] <= 1'b1;
    $display("hardware reset done");
    wr(4'h0, 8'h04);
    lvl[2] <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({8'h0, wblk}, 9'h1);
    wr(4'h0, 8'h05);
    repeat (4) @(posedge clk_sys);
    chk({8'h0, wblk}, 9'h0);
    $display("write protect done");
    test_done();
  end
endmodule : serial_flash_spi_pin_front_end_tb
